/* hdl/qps_pkg.sv */
package qps_pkg;
  // opcodes seen on the serial link
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_QPROG = 8'h33;
  localparam logic [7:0] OP_SERASE = 8'h20;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  // frame clock counts
  localparam logic [5:0] CK_OPCODE = 6'h08;
  localparam logic [5:0] CK_QADDR  = 6'h0e;  // 8 serial + 6 address nibbles
  localparam logic [5:0] CK_SADDR  = 6'h20;  // 8 + 24 serial address clocks
  // array geometry
  localparam int PAGE_BYTES   = 256;
  localparam int SECTOR_BITS  = 12;         // 4 KB sector
  localparam int PROT_UNIT    = 32'h0002_0000;
  localparam int PROT_UNIT4K  = 32'h0000_1000;
  localparam int MEM_BYTES    = 32'h0100_0000;
  // status bit positions
  localparam int ST1_BUSY = 0;
  localparam int ST1_WEL  = 1;
  localparam int ST1_BP0  = 2;
  localparam int ST1_TB   = 5;
  localparam int ST1_SEC  = 6;
  localparam int ST2_QE   = 1;
  localparam int ST2_CMP  = 6;
  // self-timed operations, in microseconds, and the clock rate
  localparam int CLK_MHZ            = 100;
  localparam int PAGE_PROG_TIME_US  = 700;
  localparam int SECTOR_ERASE_TIME_US = 50000;
  localparam int PP_CYCLES = PAGE_PROG_TIME_US * CLK_MHZ;
  localparam int SE_CYCLES = SECTOR_ERASE_TIME_US * CLK_MHZ;
  // host serial clock: half period in clk cycles (4.17 MHz, below 5 MHz)
  localparam int SCLK_HALF = 12;
  // host command port registers
  localparam logic [1:0] HREG_CMD    = 2'h0;
  localparam logic [1:0] HREG_ADDR   = 2'h1;
  localparam logic [1:0] HREG_DATA   = 2'h2;
  localparam logic [1:0] HREG_STATUS = 2'h3;
  // host command codes in the command register
  typedef enum logic [1:0] {HOP_WREN, HOP_QPROG, HOP_SERASE, HOP_RDSR} qps_hop_e;
endpackage

/* hdl/qps_if.sv */
`timescale 1ns/1ps
interface qps_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  logic [3:0] io;

  // lane level: driver wins, otherwise weak pull-up reads as 1
  assign io = (dev_io_oe & dev_io_o) | (host_io_oe & ~dev_io_oe & host_io_o)
            | ~(dev_io_oe | host_io_oe);

  modport host (output cs_n, output sclk, output host_io_o, output host_io_oe, input io);
  modport dev  (input cs_n, input sclk, input io, output dev_io_o, output dev_io_oe);
endinterface

/* hdl/qps_dev.sv */
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module qps_dev
  import qps_pkg::*;
#(
  parameter int PROG_CYCLES  = qps_pkg::PP_CYCLES,
  parameter int ERASE_CYCLES = qps_pkg::SE_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // serial link
  qps_if.dev               lnk,
  // configuration straps
  input  wire logic        quad_lane_permit,
  input  wire logic [2:0]  protect_range,
  input  wire logic        protect_top_bottom,
  input  wire logic        protect_granularity,
  input  wire logic        protect_complement,
  // array write side
  output logic             arr_prog_we,
  output logic [23:0]      arr_prog_addr,
  output logic [7:0]       arr_prog_data,
  output logic             arr_erase_we,
  output logic [23:0]      arr_erase_addr,
  // status
  output logic             busy,
  output logic             write_permit_latch
);
  import qps_pkg::*;

  typedef enum {DS_IDLE, DS_PROG, DS_ERASE} qps_dst_e;

  // protection decode, used for program and erase
  function automatic logic prot_hit(input logic [23:0] a);
    logic [24:0] size;
    logic        hit;
    size = '0;
    if (protect_range == 3'h7) begin
      size = 25'(MEM_BYTES);
    end else if (protect_range != 3'h0 && protect_granularity) begin
      size = 25'(PROT_UNIT4K) << ((protect_range > 3'h4) ? 3'h3 : protect_range - 3'h1);
    end else if (protect_range != 3'h0) begin
      size = 25'(PROT_UNIT) << (protect_range - 3'h1);
    end
    if (protect_top_bottom) begin
      hit = {1'b0, a} < size;
    end else begin
      hit = {1'b0, a} >= 25'(MEM_BYTES) - size;
    end
    return hit ^ protect_complement;
  endfunction

  // two-stage synchronisers: {cs_n, sclk, io}
  logic [5:0] s1_r, s2_r;
  logic       sclk_d_r, cs_d_r;
  logic       ck_rise, ck_fall, cs_up, cs_hi;
  logic [3:0] lane;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // idle levels: select high, clock low, lanes pulled up; no false edge after reset
      s1_r     <= 6'h2f;
      s2_r     <= 6'h2f;
      sclk_d_r <= 1'b0;
      cs_d_r   <= 1'b1;
    end else begin
      s1_r     <= {lnk.cs_n, lnk.sclk, lnk.io};
      s2_r     <= s1_r;
      sclk_d_r <= s2_r[4];
      cs_d_r   <= s2_r[5];
    end
  end

  assign cs_hi   = s2_r[5];
  assign lane    = s2_r[3:0];
  assign ck_rise = !cs_hi && s2_r[4] && !sclk_d_r;
  assign ck_fall = !cs_hi && !s2_r[4] && sclk_d_r;
  assign cs_up   = cs_hi && !cs_d_r;

  // frame decode state
  logic [5:0]   ck_r, ck_nxt;
  logic [7:0]   op_r, op_nxt;
  logic [23:0]  adr_r, adr_nxt;
  logic [3:0]   nib_r, nib_nxt;
  logic         half_r, half_nxt;
  logic         got_r, got_nxt;
  logic         ok_r, ok_nxt;
  logic [7:0]   ptr_r, ptr_nxt;
  logic [2:0]   bi_r, bi_nxt;
  logic         dout_r, dout_nxt;
  logic [255:0] mask_r, mask_nxt;
  logic         buf_we;
  logic [7:0]   buf_wd;
  logic [7:0]   page_buf [PAGE_BYTES];
  // operation state
  qps_dst_e     st_r, st_nxt;
  logic [31:0]  tmr_r, tmr_nxt;
  logic         wel_r, wel_nxt;
  logic [23:0]  base_r, base_nxt;
  logic [8:0]   walk_r, walk_nxt;
  logic         pwe_nxt, ewe_nxt;
  logic [23:0]  paddr_nxt, eaddr_nxt;
  logic [7:0]   pdata_nxt;
  logic [7:0]   stat1, stat2, stat_sel;
  logic         rd_op;

  assign stat1 = (8'(st_r != DS_IDLE) << ST1_BUSY) | (8'(wel_r) << ST1_WEL)
               | (8'(protect_range) << ST1_BP0) | (8'(protect_top_bottom) << ST1_TB)
               | (8'(protect_granularity) << ST1_SEC);
  assign stat2 = (8'(quad_lane_permit) << ST2_QE) | (8'(protect_complement) << ST2_CMP);
  assign rd_op    = (op_r == OP_RDSR1) || (op_r == OP_RDSR2);
  assign stat_sel = (op_r == OP_RDSR2) ? stat2 : stat1;

  // next-state: frame shifting, command decode, self-timed operations
  always_comb begin
    ck_nxt    = ck_r;
    op_nxt    = op_r;
    adr_nxt   = adr_r;
    nib_nxt   = nib_r;
    half_nxt  = half_r;
    got_nxt   = got_r;
    ok_nxt    = ok_r;
    ptr_nxt   = ptr_r;
    bi_nxt    = bi_r;
    dout_nxt  = dout_r;
    mask_nxt  = mask_r;
    buf_we    = 1'b0;
    buf_wd    = {nib_r, lane};
    st_nxt    = st_r;
    tmr_nxt   = tmr_r;
    wel_nxt   = wel_r;
    base_nxt  = base_r;
    walk_nxt  = walk_r;
    pwe_nxt   = 1'b0;
    paddr_nxt = arr_prog_addr;
    pdata_nxt = arr_prog_data;
    ewe_nxt   = 1'b0;
    eaddr_nxt = arr_erase_addr;
    if (cs_hi) begin
      ck_nxt   = '0;
      half_nxt = 1'b0;
      got_nxt  = 1'b0;
      bi_nxt   = '0;
    end else if (ck_rise) begin
      if (ck_r < CK_OPCODE) begin
        op_nxt = {op_r[6:0], lane[0]};
        ck_nxt = ck_r + 6'h01;
        if (ck_r == CK_OPCODE - 6'h01) begin
          // a busy device takes only status reads; frame is inert otherwise
          ok_nxt = (st_r == DS_IDLE);
          if (st_r == DS_IDLE && {op_r[6:0], lane[0]} == OP_QPROG) begin
            mask_nxt = '0;
          end
        end
      end else if (op_r == OP_QPROG) begin
        if (ck_r < CK_QADDR) begin
          adr_nxt = {adr_r[19:0], lane};
          ck_nxt  = ck_r + 6'h01;
          ptr_nxt = {adr_r[3:0], lane};
        end else if (!half_r) begin
          nib_nxt  = lane;
          half_nxt = 1'b1;
        end else begin
          buf_we   = ok_r;
          mask_nxt[ptr_r] = mask_r[ptr_r] | ok_r;
          ptr_nxt  = ptr_r + 8'h01;
          half_nxt = 1'b0;
          got_nxt  = 1'b1;
        end
      end else if (op_r == OP_SERASE) begin
        if (ck_r < CK_SADDR) begin
          adr_nxt = {adr_r[22:0], lane[0]};
          ck_nxt  = ck_r + 6'h01;
        end else begin
          ck_nxt  = CK_SADDR + 6'h01; // clocks past the address spoil it
        end
      end else if (ck_r != 6'h3f) begin
        ck_nxt = ck_r + 6'h01;
      end
    end else if (ck_fall && rd_op && ck_r >= CK_OPCODE) begin
      dout_nxt = stat_sel[~bi_r];
      bi_nxt   = bi_r + 3'h1;
    end
    // command execution on chip select release
    if (cs_up && ok_r && st_r == DS_IDLE) begin
      if (op_r == OP_WREN && ck_r == CK_OPCODE) begin
        wel_nxt = 1'b1;
      end
      if (op_r == OP_QPROG && ck_r == CK_QADDR && got_r && !half_r
          && quad_lane_permit && wel_r && !prot_hit(adr_r)) begin
        st_nxt   = DS_PROG;
        tmr_nxt  = 32'(PROG_CYCLES - 1);
        base_nxt = {adr_r[23:8], 8'h00};
        walk_nxt = '0;
        wel_nxt  = 1'b0;
      end
      if (op_r == OP_SERASE && ck_r == CK_SADDR && wel_r
          && !prot_hit(adr_r)) begin
        st_nxt    = DS_ERASE;
        tmr_nxt   = 32'(ERASE_CYCLES - 1);
        ewe_nxt   = 1'b1;
        eaddr_nxt = {adr_r[23:SECTOR_BITS], SECTOR_BITS'(0)};
        wel_nxt   = 1'b0;
      end
    end
    unique case (st_r)
      DS_IDLE: begin
      end
      DS_PROG: begin
        // walk the page buffer; untouched bytes are not written
        if (!walk_r[8]) begin
          pwe_nxt   = mask_r[walk_r[7:0]];
          paddr_nxt = base_r | {16'h0000, walk_r[7:0]};
          pdata_nxt = page_buf[walk_r[7:0]]; // array ANDs this in
          walk_nxt  = walk_r + 9'h001;
        end
        tmr_nxt = tmr_r - 32'h1;
        if (tmr_r == 32'h0) begin
          st_nxt = DS_IDLE;
        end
      end
      DS_ERASE: begin
        tmr_nxt = tmr_r - 32'h1;
        if (tmr_r == 32'h0) begin
          st_nxt = DS_IDLE;
        end
      end
    endcase
  end

  // page buffer storage; no reset needed, mask says what is valid
  always_ff @(posedge clk) begin
    if (buf_we) begin
      page_buf[ptr_r] <= buf_wd;
    end
  end

  // register all state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ck_r           <= '0;
      op_r           <= '0;
      adr_r          <= '0;
      nib_r          <= '0;
      half_r         <= 1'b0;
      got_r          <= 1'b0;
      ok_r           <= 1'b0;
      ptr_r          <= '0;
      bi_r           <= '0;
      dout_r         <= 1'b0;
      mask_r         <= '0;
      st_r           <= DS_IDLE;
      tmr_r          <= '0;
      wel_r          <= 1'b0;
      base_r         <= '0;
      walk_r         <= '0;
      arr_prog_we    <= 1'b0;
      arr_prog_addr  <= '0;
      arr_prog_data  <= 8'hff;
      arr_erase_we   <= 1'b0;
      arr_erase_addr <= '0;
    end else begin
      ck_r           <= ck_nxt;
      op_r           <= op_nxt;
      adr_r          <= adr_nxt;
      nib_r          <= nib_nxt;
      half_r         <= half_nxt;
      got_r          <= got_nxt;
      ok_r           <= ok_nxt;
      ptr_r          <= ptr_nxt;
      bi_r           <= bi_nxt;
      dout_r         <= dout_nxt;
      mask_r         <= mask_nxt;
      st_r           <= st_nxt;
      tmr_r          <= tmr_nxt;
      wel_r          <= wel_nxt;
      base_r         <= base_nxt;
      walk_r         <= walk_nxt;
      arr_prog_we    <= pwe_nxt;
      arr_prog_addr  <= paddr_nxt;
      arr_prog_data  <= pdata_nxt;
      arr_erase_we   <= ewe_nxt;
      arr_erase_addr <= eaddr_nxt;
    end
  end

  // status answers go out on lane 1 only
  assign lnk.dev_io_o   = {2'b00, dout_r, 1'b0};
  assign lnk.dev_io_oe  = {2'b00, (!cs_hi && rd_op && ck_r >= CK_OPCODE), 1'b0};
  assign busy               = (st_r != DS_IDLE);
  assign write_permit_latch = wel_r;
endmodule

/* hdl/qps_host.sv */
`timescale 1ns/1ps
module qps_host
  import qps_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // command port
  input  wire logic [1:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // serial link
  qps_if.host              lnk
);
  import qps_pkg::*;

  typedef enum {HS_IDLE, HS_LEAD, HS_RUN, HS_TAIL, HS_GAP} qps_hst_e;

  // io1 comes from the device: two flops before use
  logic io1_s1_r, io1_s2_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      io1_s1_r <= 1'b1;
      io1_s2_r <= 1'b1;
    end else begin
      io1_s1_r <= lnk.io[1];
      io1_s2_r <= io1_s1_r;
    end
  end

  qps_hst_e    st_r, st_nxt;
  qps_hop_e    op_r, op_nxt;
  logic [1:0]  len_r, len_nxt;
  logic [23:0] adr_r, adr_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [63:0] sh_r, sh_nxt;
  logic [5:0]  ck_r, ck_nxt, total;
  logic [4:0]  div_r, div_nxt;
  logic        sclk_r, sclk_nxt;
  logic        cs_n_r, cs_n_nxt;
  logic [7:0]  rx_r, rx_nxt;
  logic [31:0] rdata_nxt;
  logic        tick, quad, past_op;
  logic [7:0]  opcode;

  assign tick = (div_r == 5'(SCLK_HALF - 1));
  // opcode ends at the fall after its 8th clock; switching lanes at the rise would spoil bit 0
  assign past_op = (ck_r > CK_OPCODE) || (ck_r == CK_OPCODE && !sclk_r);
  // quad lanes carry address and data after the serial opcode
  assign quad    = (op_r == HOP_QPROG) && past_op;
  always_comb begin
    unique case (op_r)
      HOP_WREN:   opcode = OP_WREN;
      HOP_QPROG:  opcode = OP_QPROG;
      HOP_SERASE: opcode = OP_SERASE;
      HOP_RDSR:   opcode = OP_RDSR1;
    endcase
    unique case (op_r)
      HOP_WREN:   total = CK_OPCODE;
      HOP_QPROG:  total = CK_QADDR + {3'h0, len_r, 1'b0} + 6'h02; // whole bytes
      HOP_SERASE: total = CK_SADDR;
      HOP_RDSR:   total = CK_OPCODE + 6'h08;
    endcase
  end

  // next-state: register port and link sequencer
  always_comb begin
    st_nxt    = st_r;
    op_nxt    = op_r;
    len_nxt   = len_r;
    adr_nxt   = adr_r;
    dat_nxt   = dat_r;
    sh_nxt    = sh_r;
    ck_nxt    = ck_r;
    div_nxt   = tick ? 5'h00 : div_r + 5'h01;
    sclk_nxt  = sclk_r;
    cs_n_nxt  = cs_n_r;
    rx_nxt    = rx_r;
    rdata_nxt = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        HREG_CMD:    rdata_nxt = {28'h0, len_r, op_r};
        HREG_ADDR:   rdata_nxt = {8'h00, adr_r};
        HREG_DATA:   rdata_nxt = dat_r;
        HREG_STATUS: rdata_nxt = {16'h0000, rx_r, 7'h00, (st_r != HS_IDLE)};
      endcase
    end
    // writes while a frame runs are ignored
    if (reg_wr && st_r == HS_IDLE) begin
      unique case (reg_addr)
        HREG_CMD: begin
          op_nxt  = qps_hop_e'(reg_wdata[1:0]);
          len_nxt = reg_wdata[3:2];
          st_nxt  = HS_LEAD;
          div_nxt = '0;
          ck_nxt  = '0;
        end
        HREG_ADDR: adr_nxt = reg_wdata[23:0];
        HREG_DATA: dat_nxt = reg_wdata;
        default: begin
        end
      endcase
    end
    unique case (st_r)
      HS_IDLE: begin
      end
      HS_LEAD: begin
        cs_n_nxt = 1'b0;
        sh_nxt   = {opcode, adr_r, dat_r};
        if (tick) begin
          st_nxt = HS_RUN;
        end
      end
      HS_RUN: begin
        // chip select stays low for the whole command
        if (tick && !sclk_r) begin
          sclk_nxt = 1'b1;
          ck_nxt   = ck_r + 6'h01;
          rx_nxt   = (op_r == HOP_RDSR) ? {rx_r[6:0], io1_s2_r} : rx_r;
        end else if (tick) begin
          sclk_nxt = 1'b0;
          sh_nxt   = quad ? {sh_r[59:0], 4'h0} : {sh_r[62:0], 1'b0};
          if (ck_r == total) begin
            st_nxt = HS_TAIL;
          end
        end
      end
      HS_TAIL: begin
        if (tick) begin
          cs_n_nxt = 1'b1;
          st_nxt   = HS_GAP;
        end
      end
      HS_GAP: begin
        if (tick) begin
          st_nxt = HS_IDLE;
        end
      end
    endcase
  end

  // register all state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r      <= HS_IDLE;
      op_r      <= HOP_WREN;
      len_r     <= '0;
      adr_r     <= '0;
      dat_r     <= '0;
      sh_r      <= '0;
      ck_r      <= '0;
      div_r     <= '0;
      sclk_r    <= 1'b0;
      cs_n_r    <= 1'b1;
      rx_r      <= '0;
      reg_rdata <= '0;
    end else begin
      st_r      <= st_nxt;
      op_r      <= op_nxt;
      len_r     <= len_nxt;
      adr_r     <= adr_nxt;
      dat_r     <= dat_nxt;
      sh_r      <= sh_nxt;
      ck_r      <= ck_nxt;
      div_r     <= div_nxt;
      sclk_r    <= sclk_nxt;
      cs_n_r    <= cs_n_nxt;
      rx_r      <= rx_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  // slow serial clock keeps quad transfers worthwhile
  assign lnk.sclk       = sclk_r;
  assign lnk.cs_n       = cs_n_r;
  assign lnk.host_io_o  = quad ? sh_r[63:60] : {3'b000, sh_r[63]};
  assign lnk.host_io_oe = (cs_n_r || (op_r == HOP_RDSR && past_op)) ? 4'h0 :
                          (quad ? 4'hf : 4'h1);
endmodule

/* test/qps_assertions.sv */
`timescale 1ns/1ps
module qps_assertions
  import qps_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // link
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic [3:0] host_io_o,
  input  wire logic [3:0] host_io_oe,
  input  wire logic [3:0] dev_io_oe,
  // device status
  input  wire logic       busy,
  input  wire logic       write_permit_latch
);
  logic [5:0] hi_cnt_r;
  logic [5:0] hi_cnt_nxt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // length of the running sclk high phase, checked at its end
  always_comb begin
    hi_cnt_nxt = sclk ? hi_cnt_r + 6'h01 : 6'h00;
  end
  always_ff @(posedge clk) begin
    hi_cnt_r <= rst_n ? hi_cnt_nxt : 6'h00;
  end

  // a frame closes when select returns high
  sequence s_frame_end;
    $rose(cs_n);
  endsequence
  // device lets go of its lanes shortly after; sync delay allows a few cycles
  sequence s_dev_release;
    ##[0:8] (dev_io_oe == 4'h0);
  endsequence

  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  a_cs_edge_sclk: assert property (s_frame_end |-> !sclk && !$past(sclk))
    else $error("select rose in the middle of a clock");
  a_lanes_hold_high: assert property ((sclk && $past(sclk)) |-> $stable(host_io_o))
    else $error("host lane data moved while clock high");
  a_sclk_half_len: assert property ($fell(sclk) |-> hi_cnt_r == 6'(SCLK_HALF))
    else $error("serial clock high phase has wrong length");
  a_no_lane_fight: assert property ((host_io_oe & dev_io_oe) == 4'h0)
    else $error("both ends drive one lane");
  a_dev_lets_go: assert property (s_frame_end |-> s_dev_release)
    else $error("device still drives after frame end");
  a_dev_one_lane: assert property (dev_io_oe[3:2] == 2'h0 && !dev_io_oe[0])
    else $error("device drives a lane other than lane 1");
  a_busy_clr_latch: assert property ($rose(busy) |-> ##[0:1] !write_permit_latch)
    else $error("write latch not cleared when busy set");
  a_busy_after_cs: assert property ($rose(busy) |-> cs_n && $past(cs_n))
    else $error("busy started inside a frame");
endmodule

/* test/quad_program_sector_erase_tb_top.sv */
`timescale 1ns/1ps
module quad_program_sector_erase_tb_top;
  import qps_pkg::*;
  // long self-timed counts shortened; busy must outlast one status frame
  localparam int PROG_N  = 3000;
  localparam int ERASE_N = 4000;

  logic        clk;
  logic        rst_n;
  logic [1:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        quad_lane_permit;
  logic [2:0]  protect_range;
  logic        protect_top_bottom;
  logic        protect_granularity;
  logic        protect_complement;
  logic        arr_prog_we;
  logic [23:0] arr_prog_addr;
  logic [7:0]  arr_prog_data;
  logic        arr_erase_we;
  logic [23:0] arr_erase_addr;
  logic        busy;
  logic        write_permit_latch;
  logic [7:0]  mem [int];
  logic [3:0]  lane_q [$];
  logic        sclk_q;
  logic [23:0] erase_base;
  logic [31:0] rd_v;
  logic [7:0]  st;
  int          n_mismatch;
  int          samples_checked;
  int          n_prog;
  int          n_erase;
  int          busy_len;
  int          last_busy;
  int          cycles;

  qps_if u_qps_if ();
  qps_dev #(.PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N)) u_qps_dev (
    .clk(clk), .rst_n(rst_n), .lnk(u_qps_if),
    .quad_lane_permit(quad_lane_permit), .protect_range(protect_range),
    .protect_top_bottom(protect_top_bottom), .protect_granularity(protect_granularity),
    .protect_complement(protect_complement),
    .arr_prog_we(arr_prog_we), .arr_prog_addr(arr_prog_addr), .arr_prog_data(arr_prog_data),
    .arr_erase_we(arr_erase_we), .arr_erase_addr(arr_erase_addr),
    .busy(busy), .write_permit_latch(write_permit_latch));
  qps_host u_qps_host (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lnk(u_qps_if));
  qps_assertions chk (
    .clk(clk), .rst_n(rst_n), .cs_n(u_qps_if.cs_n), .sclk(u_qps_if.sclk),
    .host_io_o(u_qps_if.host_io_o), .host_io_oe(u_qps_if.host_io_oe),
    .dev_io_oe(u_qps_if.dev_io_oe), .busy(busy), .write_permit_latch(write_permit_latch));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [7:0] rd_mem(input int a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction

  // array model (erased array reads ff), lane monitor, busy length, watchdog
  always @(posedge clk) begin
    cycles++;
    sclk_q <= u_qps_if.sclk;
    if (!u_qps_if.cs_n && u_qps_if.sclk && !sclk_q) lane_q.push_back(u_qps_if.io);
    if (arr_prog_we === 1'b1) begin
      mem[arr_prog_addr] = rd_mem(arr_prog_addr) & arr_prog_data;
      n_prog++;
    end
    if (arr_erase_we === 1'b1) begin
      for (int i = 0; i < 4096; i++) mem[{arr_erase_addr[23:12], 12'(i)}] = 8'hff;
      erase_base = arr_erase_addr;
      n_erase++;
    end
    if (busy === 1'b1) busy_len++;
    else if (busy_len != 0) begin
      last_busy = busy_len;
      busy_len = 0;
    end
    if (cycles == 80000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic results();
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stand from the cycle after the strobe until the next read
  task automatic reg_read(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  // one link frame, waited out on the frame-active flag
  task automatic run_cmd(input qps_hop_e op, input logic [1:0] len, input logic [23:0] a,
                         input logic [31:0] d);
    int i;
    reg_write(HREG_ADDR, {8'h00, a});
    reg_write(HREG_DATA, d);
    lane_q.delete();
    reg_write(HREG_CMD, {28'h0, len, op});
    i = 0;
    rd_v = 32'h1;
    while (rd_v[0] === 1'b1 && i < 3000) begin
      reg_read(HREG_STATUS, rd_v);
      i++;
    end
    check({31'h0, rd_v[0]}, 32'h0);
  endtask

  task automatic check_st(input logic b, input logic l);
    run_cmd(HOP_RDSR, 2'h0, 24'h0, 32'h0);
    reg_read(HREG_STATUS, rd_v);
    st = rd_v[15:8];
    check({25'h0, st[6:0]}, {25'h0, protect_granularity, protect_top_bottom, protect_range, l, b});
  endtask

  // rebuild opcode, address and data from the sampled lanes
  task automatic check_wire(input logic [7:0] op_e, input logic [23:0] a_e, input logic [31:0] d_e);
    logic [7:0]  op;
    logic [23:0] a;
    logic [31:0] d;
    op = 8'h0;
    a = 24'h0;
    d = 32'h0;
    for (int k = 0; k < 8; k++) op = {op[6:0], lane_q[k][0]};
    check({24'h0, op}, {24'h0, op_e});
    if (op_e == OP_SERASE) begin
      for (int k = 8; k < 32; k++) a = {a[22:0], lane_q[k][0]};
      check(32'(lane_q.size()), 32'd32);
    end else begin
      for (int k = 8; k < 14; k++) a = {a[19:0], lane_q[k]};
      for (int k = 14; k < 22; k++) d = {d[27:0], lane_q[k]};
      check(d, d_e);
    end
    check({8'h0, a}, {8'h0, a_e});
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 20000 && busy !== 1'b0; i++) @(posedge clk);
    check(32'(busy), 32'h0);
    repeat (2) @(posedge clk);
  endtask

  initial begin
    rst_n = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    quad_lane_permit = 1'b1;
    protect_range = 3'h0;
    protect_top_bottom = 1'b0;
    protect_granularity = 1'b0;
    protect_complement = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check_st(1'b0, 1'b0);
    // program with no write latch is dropped
    run_cmd(HOP_QPROG, 2'h3, 24'h000100, 32'h0);
    repeat (300) @(posedge clk);
    check(32'(n_prog), 32'd0);
    run_cmd(HOP_WREN, 2'h0, 24'h0, 32'h0);
    check_st(1'b0, 1'b1);
    // quad permit off: dropped too
    quad_lane_permit <= 1'b0;
    run_cmd(HOP_QPROG, 2'h3, 24'h000100, 32'h0);
    repeat (300) @(posedge clk);
    check(32'(n_prog), 32'd0);
    quad_lane_permit <= 1'b1;
    // four bytes from fe wrap inside the page
    run_cmd(HOP_QPROG, 2'h3, 24'h0001fe, 32'h1234_5678);
    check_wire(OP_QPROG, 24'h0001fe, 32'h1234_5678);
    check_st(1'b1, 1'b0);
    run_cmd(HOP_WREN, 2'h0, 24'h0, 32'h0);
    wait_idle();
    check(32'(n_prog), 32'd4);
    check(32'(rd_mem(32'h1fe)), 32'h12);
    check(32'(rd_mem(32'h1ff)), 32'h34);
    check(32'(rd_mem(32'h100)), 32'h56);
    check(32'(rd_mem(32'h101)), 32'h78);
    check_st(1'b0, 1'b0);
    // a second program only clears bits
    run_cmd(HOP_WREN, 2'h0, 24'h0, 32'h0);
    run_cmd(HOP_QPROG, 2'h0, 24'h000100, 32'hf000_0000);
    wait_idle();
    check(32'(rd_mem(32'h100)), 32'h50);
    // erase with no latch, then into a protected area
    run_cmd(HOP_SERASE, 2'h0, 24'h000123, 32'h0);
    repeat (300) @(posedge clk);
    check(32'(n_erase), 32'd0);
    run_cmd(HOP_WREN, 2'h0, 24'h0, 32'h0);
    protect_range <= 3'h7;
    run_cmd(HOP_SERASE, 2'h0, 24'h000123, 32'h0);
    repeat (300) @(posedge clk);
    check(32'(n_erase), 32'd0);
    protect_range <= 3'h0;
    run_cmd(HOP_WREN, 2'h0, 24'h0, 32'h0);
    run_cmd(HOP_SERASE, 2'h0, 24'h000123, 32'h0);
    check_wire(OP_SERASE, 24'h000123, 32'h0);
    check_st(1'b1, 1'b0);
    wait_idle();
    check(32'(n_erase), 32'd1);
    check({8'h0, erase_base}, 32'h0);
    check(32'(rd_mem(32'h1fe)), 32'hff);
    check(32'(rd_mem(32'h100)), 32'hff);
    check(32'(last_busy >= ERASE_N && last_busy <= ERASE_N + 4), 32'd1);
    check_st(1'b0, 1'b0);
    results();
  end
endmodule
